//--- design/cdsr_regs.sv
// divider registers for channels 2 and 3 and the shared status register
//
// Operation
// R1: ch2 sensor divider bits 15:12 divides sensor
// R2: host never writes zero sensor divider
// R3: host sets divider two above 8.75MHz
// R4: ch2 reference divider bits 9:0 divides mclk
// R5: host never writes zero reference divider
// R6: host writes zeros to bits 11:10
// R7: ch3 has same divider layout
// R8: ch3 reference zero reserved, else divides
// R9: host sets ch3 divider two when fast
// R10: status 15:14 binary source channel code
// R11: error latched until status or data read
// R12: bit 13 under-range since last read
// R13: bit 12 over-range since last read
// R14: status read-only, resets to zero
// R15: bit 6 new result ready
// R16: bits 3:0 unread results, cleared by read
// R17: bits 11:8 watchdog, amp high/low, zero-count
`timescale 1ns/1ns
module cdsr_regs (
   input wire logic mclk,
   input wire logic rst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   input wire logic ch2_sensor_clk,
   input wire logic ch3_sensor_clk,
   output logic ch2_fin,
   output logic ch3_fin,
   output logic ch2_fref,
   output logic ch3_fref,
   input wire logic [5:0] err_event,
   input wire logic [1:0] fault_channel_id,
   input wire logic result_done,
   input wire logic [3:0] chan_done,
   input wire logic data_rd,
   input wire logic [1:0] data_rd_chan,
   output logic [15:0] status_now
);
   // ****************************************************************
   // register and pin state
   // ****************************************************************
   logic [15:0] div2_reg, div2_next, div3_reg, div3_next;
   logic [1:0] chan_reg, chan_next;
   logic [5:0] err_reg, err_next;
   logic result_ready_flag_reg, result_ready_flag_next;
   logic [3:0] pend_reg, pend_next;
   logic [15:0] rdata_reg, rdata_next;
   logic [15:0] stat;
   logic s2a_reg, s2b_reg, s3a_reg, s3b_reg, s2c_reg, s3c_reg;
   logic [3:0] fc2_reg, fc2_next, fc3_reg, fc3_next;
   logic [9:0] rc2_reg, rc2_next, rc3_reg, rc3_next;
   logic fin2_reg, fin2_next, fin3_reg, fin3_next;
   logic fr2_reg, fr2_next, fr3_reg, fr3_next;
   logic st_rd, err_clr;
   logic [3:0] s2_div, s3_div;
   logic [9:0] r2_div, r3_div;

   // ****************************************************************
   // status word
   // ****************************************************************
   always_comb begin
      stat = 16'h0000;
      // R10: source channel code
      stat[cdsr_pkg::ST_CHAN_HI:cdsr_pkg::ST_CHAN_LO] = chan_reg;
      // R12: under-range flag
      stat[cdsr_pkg::ST_UR] = err_reg[cdsr_pkg::E_UR];
      // R13: over-range flag
      stat[cdsr_pkg::ST_OR] = err_reg[cdsr_pkg::E_OR];
      // R17: remaining error flags
      stat[cdsr_pkg::ST_WD] = err_reg[cdsr_pkg::E_WD];
      stat[cdsr_pkg::ST_AHE] = err_reg[cdsr_pkg::E_AHE];
      stat[cdsr_pkg::ST_ALE] = err_reg[cdsr_pkg::E_ALE];
      stat[cdsr_pkg::ST_ZC] = err_reg[cdsr_pkg::E_ZC];
      stat[cdsr_pkg::ST_RESULT_READY_FLAG] = result_ready_flag_reg;
      // bit 3 is channel 0 down to bit 0 channel 3
      stat[3:0] = {pend_reg[0], pend_reg[1], pend_reg[2], pend_reg[3]};
   end

   // ****************************************************************
   // register bank next state
   // ****************************************************************
   always_comb begin
      st_rd = reg_rd && (reg_addr == cdsr_pkg::ADDR_STATUS);
      // R11: clear on status read or data read of the named channel
      err_clr = st_rd || (data_rd && (data_rd_chan == chan_reg));
      div2_next = div2_reg;
      div3_next = div3_reg;
      // R1: whole register written as given, reserved bits 11:10 included
      if (reg_wr && reg_addr == cdsr_pkg::ADDR_CH2_DIV) begin
         div2_next = reg_wdata;
      end
      // R7: channel 3 register of the same layout
      if (reg_wr && reg_addr == cdsr_pkg::ADDR_CH3_DIV) begin
         div3_next = reg_wdata;
      end
      // R14: status is read-only; writes to it are ignored
      err_next = err_clr ? 6'h00 : err_reg;
      chan_next = chan_reg;
      // R11: set wins over a same-cycle clear
      if (|err_event) begin
         err_next = err_next | err_event;
         chan_next = fault_channel_id;
      end
      // R15: ready flag, cleared by status read, set wins
      result_ready_flag_next = (result_ready_flag_reg && !st_rd) || result_done;
      // R16: per-channel unread flags cleared by data read
      pend_next = pend_reg;
      if (data_rd) begin
         pend_next[data_rd_chan] = 1'b0;
      end
      pend_next = pend_next | chan_done;
      rdata_next = rdata_reg;
      if (reg_rd) begin
         case (reg_addr)
            cdsr_pkg::ADDR_CH2_DIV: rdata_next = div2_reg;
            cdsr_pkg::ADDR_CH3_DIV: rdata_next = div3_reg;
            cdsr_pkg::ADDR_STATUS: rdata_next = stat;
            default: rdata_next = 16'h0000;
         endcase
      end
   end

   // ****************************************************************
   // clock dividers
   // ****************************************************************
   // zero is reserved; treated as one so the clock never stalls
   always_comb begin
      s2_div = div2_reg[cdsr_pkg::SENS_DIV_HI:cdsr_pkg::SENS_DIV_LO];
      s3_div = div3_reg[cdsr_pkg::SENS_DIV_HI:cdsr_pkg::SENS_DIV_LO];
      r2_div = div2_reg[cdsr_pkg::REF_DIV_HI:cdsr_pkg::REF_DIV_LO];
      r3_div = div3_reg[cdsr_pkg::REF_DIV_HI:cdsr_pkg::REF_DIV_LO];
      if (s2_div == cdsr_pkg::SENS_DIV_ZERO) s2_div = cdsr_pkg::SENS_DIV_ONE;
      if (s3_div == cdsr_pkg::SENS_DIV_ZERO) s3_div = cdsr_pkg::SENS_DIV_ONE;
      // R8: zero reference setting held at divide-by-one
      if (r2_div == cdsr_pkg::REF_DIV_ZERO) r2_div = cdsr_pkg::REF_DIV_ONE;
      if (r3_div == cdsr_pkg::REF_DIV_ZERO) r3_div = cdsr_pkg::REF_DIV_ONE;
      // R1: one output pulse per s2_div rising sensor edges
      fc2_next = fc2_reg;
      fin2_next = 1'b0;
      if (s2c_reg == 1'b0 && s2b_reg == 1'b1) begin
         fin2_next = (fc2_reg + 4'h1 >= s2_div);
         fc2_next = fin2_next ? 4'h0 : fc2_reg + 4'h1;
      end
      fc3_next = fc3_reg;
      fin3_next = 1'b0;
      if (s3c_reg == 1'b0 && s3b_reg == 1'b1) begin
         fin3_next = (fc3_reg + 4'h1 >= s3_div);
         fc3_next = fin3_next ? 4'h0 : fc3_reg + 4'h1;
      end
      // R4: one reference pulse per r2_div mclk cycles
      fr2_next = (rc2_reg + 10'h001 >= r2_div);
      rc2_next = fr2_next ? 10'h000 : rc2_reg + 10'h001;
      fr3_next = (rc3_reg + 10'h001 >= r3_div);
      rc3_next = fr3_next ? 10'h000 : rc3_reg + 10'h001;
   end

   // ****************************************************************
   // registers
   // ****************************************************************
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         div2_reg <= cdsr_pkg::DIV_RESET;
         div3_reg <= cdsr_pkg::DIV_RESET;
         // R14: status resets to zero, channel code 0
         chan_reg <= cdsr_pkg::CHAN_RESET;
         err_reg <= 6'h00;
         result_ready_flag_reg <= 1'b0;
         pend_reg <= 4'h0;
         rdata_reg <= 16'h0000;
         s2a_reg <= 1'b0;
         s2b_reg <= 1'b0;
         s2c_reg <= 1'b0;
         s3a_reg <= 1'b0;
         s3b_reg <= 1'b0;
         s3c_reg <= 1'b0;
         fc2_reg <= 4'h0;
         fc3_reg <= 4'h0;
         rc2_reg <= 10'h000;
         rc3_reg <= 10'h000;
         fin2_reg <= 1'b0;
         fin3_reg <= 1'b0;
         fr2_reg <= 1'b0;
         fr3_reg <= 1'b0;
         status_now <= 16'h0000;
      end else begin
         div2_reg <= div2_next;
         div3_reg <= div3_next;
         chan_reg <= chan_next;
         err_reg <= err_next;
         result_ready_flag_reg <= result_ready_flag_next;
         pend_reg <= pend_next;
         rdata_reg <= rdata_next;
         s2a_reg <= ch2_sensor_clk;
         s2b_reg <= s2a_reg;
         s2c_reg <= s2b_reg;
         s3a_reg <= ch3_sensor_clk;
         s3b_reg <= s3a_reg;
         s3c_reg <= s3b_reg;
         fc2_reg <= fc2_next;
         fc3_reg <= fc3_next;
         rc2_reg <= rc2_next;
         rc3_reg <= rc3_next;
         fin2_reg <= fin2_next;
         fin3_reg <= fin3_next;
         fr2_reg <= fr2_next;
         fr3_reg <= fr3_next;
         status_now <= stat;
      end
   end

   assign reg_rdata = rdata_reg;
   assign ch2_fin = fin2_reg;
   assign ch3_fin = fin3_reg;
   assign ch2_fref = fr2_reg;
   assign ch3_fref = fr3_reg;
endmodule : cdsr_regs

//--- design/cdsr_pkg.sv
// package of register map, field layout and constants for the divider/status bank
package cdsr_pkg;
   localparam logic [7:0] ADDR_CH2_DIV = 8'h16;
   localparam logic [7:0] ADDR_CH3_DIV = 8'h17;
   localparam logic [7:0] ADDR_STATUS = 8'h18;
   localparam int SENS_DIV_HI = 15;
   localparam int SENS_DIV_LO = 12;
   localparam int REF_DIV_HI = 9;
   localparam int REF_DIV_LO = 0;
   localparam int RSV_HI = 11;
   localparam int RSV_LO = 10;
   localparam int ST_CHAN_HI = 15;
   localparam int ST_CHAN_LO = 14;
   localparam int ST_UR = 13;
   localparam int ST_OR = 12;
   localparam int ST_WD = 11;
   localparam int ST_AHE = 10;
   localparam int ST_ALE = 9;
   localparam int ST_ZC = 8;
   localparam int ST_RESULT_READY_FLAG = 6;
   localparam int NCHAN = 4;
   localparam int NERR = 6;
   localparam logic [15:0] DIV_RESET = 16'h0000;
   localparam logic [3:0] SENS_DIV_ONE = 4'h1;
   localparam logic [9:0] REF_DIV_ONE = 10'h001;
   localparam logic [9:0] REF_DIV_ZERO = 10'h000;
   localparam logic [3:0] SENS_DIV_ZERO = 4'h0;
   localparam logic [1:0] CHAN_RESET = 2'h0;
   // error index within the error vectors
   localparam int E_UR = 0;
   localparam int E_OR = 1;
   localparam int E_WD = 2;
   localparam int E_AHE = 3;
   localparam int E_ALE = 4;
   localparam int E_ZC = 5;
endpackage : cdsr_pkg

//--- bench/cdsr_regs_assertions.sv
// concurrent checks on the divider and status bank ports
`timescale 1ns/1ns
module cdsr_chk (
   input wire logic mclk,
   input wire logic rst,
   input wire logic reg_rd,
   input wire logic data_rd,
   input wire logic result_done,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_rdata,
   input wire logic [15:0] status_now,
   input wire logic [5:0] err_event,
   input wire logic [1:0] fault_channel_id,
   input wire logic [1:0] data_rd_chan,
   input wire logic [3:0] chan_done
);
   // ****
   // properties
   // ****
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   logic st_rd;
   assign st_rd = reg_rd && reg_addr == cdsr_pkg::ADDR_STATUS;
   property p_ur; err_event[0] |-> ##2 status_now[13]; endproperty
   a_ur: assert property (p_ur) else $error("under-range lost");
   property p_or; err_event[1] |-> ##2 status_now[12]; endproperty
   a_or: assert property (p_or) else $error("over-range lost");
   property p_wd; err_event[2] |-> ##2 status_now[11]; endproperty
   a_wd: assert property (p_wd) else $error("timeout lost");
   property p_ch; |err_event ##1 err_event == 6'h00
      |=> status_now[15:14] == $past(fault_channel_id, 2); endproperty
   a_ch: assert property (p_ch) else $error("bad channel");
   property p_clr; st_rd && err_event == 6'h00 ##1 err_event == 6'h00
      |=> status_now[13:8] == 6'h00; endproperty
   a_clr: assert property (p_clr) else $error("no clear");
   property p_rdv; st_rd |=> reg_rdata == status_now; endproperty
   a_rdv: assert property (p_rdv) else $error("bad read");
   property p_dr; result_done |-> ##2 status_now[6]; endproperty
   a_dr: assert property (p_dr) else $error("ready lost");
   property p_pd; chan_done[0] |-> ##2 status_now[3]; endproperty
   a_pd: assert property (p_pd) else $error("pending lost");
   // a fresh result in the next cycle may legally set the flag again
   property p_pc; data_rd && data_rd_chan == 2'h0 && !chan_done[0]
      ##1 !chan_done[0] |=> !status_now[3]; endproperty
   a_pc: assert property (p_pc) else $error("pending kept");
   property p_rs; disable iff (1'h0) rst |-> status_now == 16'h0000;
   endproperty
   a_rs: assert property (p_rs) else $error("reset value");
   c_ur: cover property (err_event[0]);
   c_st: cover property (st_rd);
   c_rd: cover property (data_rd);
endmodule : cdsr_chk
bind cdsr_regs cdsr_chk u_chk (.mclk(mclk), .rst(rst), .reg_rd(reg_rd),
   .data_rd(data_rd), .result_done(result_done), .reg_addr(reg_addr),
   .reg_rdata(reg_rdata), .status_now(status_now), .err_event(err_event),
   .fault_channel_id(fault_channel_id), .data_rd_chan(data_rd_chan), .chan_done(chan_done));

//--- bench/cdsr_host.sv
// host model issuing register writes and reads
`timescale 1ns/1ns
module cdsr_host (
   input wire logic mclk,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata
);
   initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [15:0] v;
      v = d;
      v[11:10] = 2'h0;
      if (v[15:12] == 4'h0) v[15:12] = 4'h1;
      if (v[9:0] == 10'h000) v[9:0] = 10'h001;
      @(negedge mclk);
      {reg_addr, reg_wdata, reg_wr} = {a, v, 1'h1};
      @(negedge mclk);
      // idle bus shows inverted data, not the last value
      {reg_addr, reg_wdata, reg_wr} = {~a, ~v, 1'h0};
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(negedge mclk);
      {reg_addr, reg_rd} = {a, 1'h1};
      @(negedge mclk);
      {reg_addr, reg_rd} = {~a, 1'h0};
      d = reg_rdata;
   endtask : rd
endmodule : cdsr_host

//--- bench/cdsr_regs_tb.sv
// self-checking bench for the divider and status bank
`timescale 1ns/1ns
module cdsr_regs_tb;
   logic mclk = 1'h0, rst = 1'h0, result_done = 1'h0, data_rd = 1'h0;
   logic ch2_sensor_clk = 1'h0, ch3_sensor_clk = 1'h0;
   logic reg_wr, reg_rd, ch2_fin, ch3_fin, ch2_fref, ch3_fref;
   logic [7:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, status_now, d;
   logic [5:0] err_event = 6'h00;
   logic [1:0] fault_channel_id = 2'h0, data_rd_chan = 2'h0;
   logic [3:0] chan_done = 4'h0, pl;
   int error_cnt = 0, checked = 0;
   assign pl = {ch3_fin, ch2_fin, ch3_fref, ch2_fref};
   always #5 mclk = ~mclk;
   always #100 ch2_sensor_clk = ~ch2_sensor_clk;
   always #70 ch3_sensor_clk = ~ch3_sensor_clk;
   cdsr_regs u_cdsr_regs (
      .mclk(mclk),
      .rst(rst),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata),
      .ch2_sensor_clk(ch2_sensor_clk),
      .ch3_sensor_clk(ch3_sensor_clk),
      .ch2_fin(ch2_fin),
      .ch3_fin(ch3_fin),
      .ch2_fref(ch2_fref),
      .ch3_fref(ch3_fref),
      .err_event(err_event),
      .fault_channel_id(fault_channel_id),
      .result_done(result_done),
      .chan_done(chan_done),
      .data_rd(data_rd),
      .data_rd_chan(data_rd_chan),
      .status_now(status_now)
   );
   cdsr_host u_cdsr_host (
      .mclk(mclk),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata)
   );
   // ****
   // tasks
   // ****
   task automatic chk(input logic [15:0] g, e);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic summarize;
      $display("errors %0d checks %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : summarize
   task automatic ev(input logic [5:0] e, input logic [1:0] c,
      input logic [3:0] cd, input logic r, dr);
      @(negedge mclk);
      {err_event, fault_channel_id, data_rd_chan, chan_done} = {e, c, c, cd};
      {result_done, data_rd} = {r, dr};
      @(negedge mclk);
      {err_event, chan_done, result_done, data_rd} = '0;
   endtask : ev
   task automatic per(input int k, input logic [15:0] e);
      logic [15:0] n;
      for (int p = 0; p < 2; p++) begin
         n = 16'h0000;
         do begin
            @(negedge mclk);
            n++;
         end while (!pl[k] && n < 16'h07d0);
      end
      if (n == 16'h07d0) begin
         error_cnt++;
         $display("[ERR] %0t divider pulse timeout", $time);
         summarize();
      end
      chk(n, e);
   endtask : per
   task automatic t_div;
      u_cdsr_host.wr(8'h16, 16'hfc05);
      u_cdsr_host.wr(8'h17, 16'h23ff);
      u_cdsr_host.wr(8'h18, 16'hffff);
      u_cdsr_host.rd(8'h16, d);
      chk(d, 16'hf005);
      u_cdsr_host.rd(8'h17, d);
      chk(d, 16'h23ff);
      u_cdsr_host.rd(8'h18, d);
      chk(d, 16'h0000);
      u_cdsr_host.rd(8'h20, d);
      chk(d, 16'h0000);
      per(0, 16'h0005);
      per(1, 16'h03ff);
      per(2, 16'h012c);
      per(3, 16'h001c);
   endtask : t_div
   task automatic t_err;
      for (int i = 0; i < 6; i++) begin
         ev(6'(1 << i), i[1:0], 4'h0, 1'h0, 1'h0);
         u_cdsr_host.rd(8'h18, d);
         chk(d, {i[1:0], 14'(1 << (13 - i))});
         u_cdsr_host.rd(8'h18, d);
         chk(d & 16'h3f00, 16'h0000);
      end
   endtask : t_err
   task automatic t_data;
      ev(6'h01, 2'h2, 4'h0, 1'h0, 1'h0);
      ev(6'h00, 2'h1, 4'h0, 1'h0, 1'h1);
      u_cdsr_host.rd(8'h18, d);
      chk(d, 16'ha000);
      ev(6'h02, 2'h2, 4'h0, 1'h0, 1'h0);
      ev(6'h00, 2'h2, 4'h0, 1'h0, 1'h1);
      u_cdsr_host.rd(8'h18, d);
      chk(d & 16'h3fff, 16'h0000);
      // channels 0 and 1 pending: an asymmetric pattern shows bit order
      ev(6'h00, 2'h1, 4'h3, 1'h1, 1'h0);
      u_cdsr_host.rd(8'h18, d);
      chk(d & 16'h3fff, 16'h004c);
      ev(6'h00, 2'h0, 4'h0, 1'h0, 1'h1);
      u_cdsr_host.rd(8'h18, d);
      chk(d & 16'h3fff, 16'h0004);
   endtask : t_data
   initial begin
      // raised off time zero so the asynchronous reset sees a real edge
      #1 rst = 1'h1;
      repeat (4) @(posedge mclk);
      @(negedge mclk);
      rst = 1'h0;
      u_cdsr_host.rd(8'h16, d);
      chk(d, 16'h0000);
      t_div();
      t_err();
      t_data();
      summarize();
   end
endmodule : cdsr_regs_tb
